// >>> srb_pkg.sv
/*
  package for the stop result register bank: register indices, field layout,
  reset values and the carrier structs for result loading and register reads.
  assumes a 24-bit result word with parity on bit 23.
*/
package srb_pkg;

  localparam int SRB_ADDR_W = 6;
  localparam int SRB_WORD_W = 24;
  localparam int SRB_VAL_W = 23;
  localparam int SRB_CNT_W = 16;
  localparam int SRB_EXT_W = 7;

  // register indices
  localparam logic [5:0] SRB_ADDR_INTERVAL3 = 6'h14;
  localparam logic [5:0] SRB_ADDR_STOP3_COARSE = 6'h15;
  localparam logic [5:0] SRB_ADDR_INTERVAL4 = 6'h16;
  localparam logic [5:0] SRB_ADDR_STOP4_COARSE = 6'h17;
  localparam logic [5:0] SRB_ADDR_INTERVAL5 = 6'h18;
  localparam logic [5:0] SRB_ADDR_STOP5_COARSE = 6'h19;
  localparam logic [5:0] SRB_ADDR_INTERVAL6 = 6'h1a;
  localparam logic [5:0] SRB_ADDR_CAL_FIRST = 6'h1b;

  // field positions
  localparam int SRB_PARITY_BIT = 23;
  localparam int SRB_VAL_MSB = 22;
  localparam int SRB_CNT_MSB = 15;

  // values after reset
  localparam logic [22:0] SRB_VAL_RESET = 23'h00_0000;
  localparam logic [23:0] SRB_WORD_ZERO = 24'h00_0000;

  // result slot selector used by the measurement side
  typedef enum logic [2:0] {
    SRB_SLOT_INTERVAL3,
    SRB_SLOT_STOP3_COARSE,
    SRB_SLOT_INTERVAL4,
    SRB_SLOT_STOP4_COARSE,
    SRB_SLOT_INTERVAL5,
    SRB_SLOT_STOP5_COARSE,
    SRB_SLOT_INTERVAL6,
    SRB_SLOT_CAL_FIRST
  } srb_slot_e;

  typedef struct packed {
    logic load;
    srb_slot_e slot;
    logic [22:0] value;
  } srb_load_s;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [5:0] addr;
  } srb_req_s;

endpackage

// >>> srb_result_bank.sv
/*
  stop result register bank: read-only result words for later stop pulses,
  with the first calibration result at the end of the group.

  index  word
  0x14   interval3 result
  0x15   stop3 coarse count
  0x16   interval4 result
  0x17   stop4 coarse count
  0x18   interval5 result
  0x19   stop5 coarse count
  0x1a   interval6 result
  0x1b   first calibration result

  word layout: parity in 23, interval and calibration values in 22:0,
  coarse counts in 15:0 with 22:16 as an averaging extension.
  parity is even over 22:0, so every word reads all-zero after reset.

  assumes the measurement engine loads one slot per cycle through load_in and
  the host port presents a decoded address with read/write strobes in clk_sys.
  the serial framing of the host port lives outside this block.
*/
//
// Operation
// - stop3 coarse count at index 0x15
// - interval4 at 0x16, coarse next
// - interval5 at 0x18, coarse at 0x19
// - interval6 at 0x1a
// - coarse count bits 15:0, extension 22:16
// - read-only, ignores writes, zero after reset
// - first calibration result at 0x1b
// - interval value 23 bits in 22:0
`timescale 1ns/1ps
module srb_result_bank
  import srb_pkg::*;
#(
  parameter int EXT_EN = 1
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // measurement engine side
  input wire srb_load_s load_in,
  input wire logic averaging_en,
  // register port
  input wire srb_req_s req_in,
  output logic [23:0] rd_data,
  output logic rd_hit,
  output logic wr_ignored
);

  ////////////////////////////////////////////////////////////////////////////
  // parity: even over the 23 payload bits, so an all-zero word reads clean
  function automatic logic [23:0] srb_word(input logic [22:0] v);
    srb_word = {^v, v};
  endfunction

  // coarse slots keep 16 bits unless averaging widens them
  function automatic logic [22:0] srb_coarse(input logic [22:0] v, input logic avg);
    logic [6:0] ext;
    ext = (avg && EXT_EN != 0) ? v[SRB_VAL_MSB:SRB_CNT_MSB+1] : 7'h00;
    srb_coarse = {ext, v[SRB_CNT_MSB:0]};
  endfunction

  // register index compare, shared by every word's decode
  function automatic logic srb_hit(input logic [5:0] a, input logic [5:0] idx);
    srb_hit = (a == idx);
  endfunction

  // load strobe for one slot
  function automatic logic srb_ld(input srb_load_s l, input srb_slot_e s);
    srb_ld = l.load && (l.slot == s);
  endfunction

  // only one hit line is ever high, so the picks can simply be or-ed together
  function automatic logic [23:0] srb_pick(input logic sel, input logic [23:0] w);
    srb_pick = sel ? w : SRB_WORD_ZERO;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // storage, indexed by slot
  logic [22:0] val_reg [8];
  logic [22:0] val_next [8];
  logic [22:0] load_word;
  logic [7:0] ld_vec;
  logic is_coarse;

  // coarse slots are masked on the way in, so reads need no slot knowledge
  assign is_coarse = (load_in.slot == SRB_SLOT_STOP3_COARSE) ||
                     (load_in.slot == SRB_SLOT_STOP4_COARSE) ||
                     (load_in.slot == SRB_SLOT_STOP5_COARSE);
  assign load_word = is_coarse ? srb_coarse(load_in.value, averaging_en)
                               : load_in.value;

  always_comb begin
    for (int i = 0; i < 8; i++) begin
      val_next[i] = ld_vec[i] ? load_word : val_reg[i];
    end
  end

  // only the measurement engine updates results; the register port never does
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < 8; i++) begin
        val_reg[i] <= SRB_VAL_RESET;
      end
    end else begin
      for (int i = 0; i < 8; i++) begin
        val_reg[i] <= val_next[i];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interval3 result at 0x14
  // 23-bit unsigned value in 22:0
  logic ld_int3;
  logic hit_int3;
  logic rd_int3;
  logic wr_int3;
  logic [23:0] word_int3;
  logic [23:0] pick_int3;

  assign ld_int3 = srb_ld(load_in, SRB_SLOT_INTERVAL3);
  assign hit_int3 = srb_hit(req_in.addr, SRB_ADDR_INTERVAL3);
  assign rd_int3 = req_in.rd & hit_int3;
  assign wr_int3 = req_in.wr & hit_int3;
  assign word_int3 = srb_word(val_reg[SRB_SLOT_INTERVAL3]);
  assign pick_int3 = srb_pick(hit_int3, word_int3);

  ////////////////////////////////////////////////////////////////////////////
  // stop3 coarse count at 0x15
  // 16-bit count in 15:0, 22:16 widen it only while averaging
  logic ld_cc3;
  logic hit_cc3;
  logic rd_cc3;
  logic wr_cc3;
  logic [23:0] word_cc3;
  logic [23:0] pick_cc3;

  assign ld_cc3 = srb_ld(load_in, SRB_SLOT_STOP3_COARSE);
  assign hit_cc3 = srb_hit(req_in.addr, SRB_ADDR_STOP3_COARSE);
  assign rd_cc3 = req_in.rd & hit_cc3;
  assign wr_cc3 = req_in.wr & hit_cc3;
  assign word_cc3 = srb_word(val_reg[SRB_SLOT_STOP3_COARSE]);
  assign pick_cc3 = srb_pick(hit_cc3, word_cc3);

  ////////////////////////////////////////////////////////////////////////////
  // interval4 result at 0x16
  // 23-bit unsigned value in 22:0
  logic ld_int4;
  logic hit_int4;
  logic rd_int4;
  logic wr_int4;
  logic [23:0] word_int4;
  logic [23:0] pick_int4;

  assign ld_int4 = srb_ld(load_in, SRB_SLOT_INTERVAL4);
  assign hit_int4 = srb_hit(req_in.addr, SRB_ADDR_INTERVAL4);
  assign rd_int4 = req_in.rd & hit_int4;
  assign wr_int4 = req_in.wr & hit_int4;
  assign word_int4 = srb_word(val_reg[SRB_SLOT_INTERVAL4]);
  assign pick_int4 = srb_pick(hit_int4, word_int4);

  ////////////////////////////////////////////////////////////////////////////
  // stop4 coarse count at 0x17, right after its interval
  // 16-bit count in 15:0, 22:16 widen it only while averaging
  logic ld_cc4;
  logic hit_cc4;
  logic rd_cc4;
  logic wr_cc4;
  logic [23:0] word_cc4;
  logic [23:0] pick_cc4;

  assign ld_cc4 = srb_ld(load_in, SRB_SLOT_STOP4_COARSE);
  assign hit_cc4 = srb_hit(req_in.addr, SRB_ADDR_STOP4_COARSE);
  assign rd_cc4 = req_in.rd & hit_cc4;
  assign wr_cc4 = req_in.wr & hit_cc4;
  assign word_cc4 = srb_word(val_reg[SRB_SLOT_STOP4_COARSE]);
  assign pick_cc4 = srb_pick(hit_cc4, word_cc4);

  ////////////////////////////////////////////////////////////////////////////
  // interval5 result at 0x18
  // 23-bit unsigned value in 22:0
  logic ld_int5;
  logic hit_int5;
  logic rd_int5;
  logic wr_int5;
  logic [23:0] word_int5;
  logic [23:0] pick_int5;

  assign ld_int5 = srb_ld(load_in, SRB_SLOT_INTERVAL5);
  assign hit_int5 = srb_hit(req_in.addr, SRB_ADDR_INTERVAL5);
  assign rd_int5 = req_in.rd & hit_int5;
  assign wr_int5 = req_in.wr & hit_int5;
  assign word_int5 = srb_word(val_reg[SRB_SLOT_INTERVAL5]);
  assign pick_int5 = srb_pick(hit_int5, word_int5);

  ////////////////////////////////////////////////////////////////////////////
  // stop5 coarse count at 0x19
  // 16-bit count in 15:0, 22:16 widen it only while averaging
  logic ld_cc5;
  logic hit_cc5;
  logic rd_cc5;
  logic wr_cc5;
  logic [23:0] word_cc5;
  logic [23:0] pick_cc5;

  assign ld_cc5 = srb_ld(load_in, SRB_SLOT_STOP5_COARSE);
  assign hit_cc5 = srb_hit(req_in.addr, SRB_ADDR_STOP5_COARSE);
  assign rd_cc5 = req_in.rd & hit_cc5;
  assign wr_cc5 = req_in.wr & hit_cc5;
  assign word_cc5 = srb_word(val_reg[SRB_SLOT_STOP5_COARSE]);
  assign pick_cc5 = srb_pick(hit_cc5, word_cc5);

  ////////////////////////////////////////////////////////////////////////////
  // interval6 result at 0x1a, the last interval slot
  // 23-bit unsigned value in 22:0
  logic ld_int6;
  logic hit_int6;
  logic rd_int6;
  logic wr_int6;
  logic [23:0] word_int6;
  logic [23:0] pick_int6;

  assign ld_int6 = srb_ld(load_in, SRB_SLOT_INTERVAL6);
  assign hit_int6 = srb_hit(req_in.addr, SRB_ADDR_INTERVAL6);
  assign rd_int6 = req_in.rd & hit_int6;
  assign wr_int6 = req_in.wr & hit_int6;
  assign word_int6 = srb_word(val_reg[SRB_SLOT_INTERVAL6]);
  assign pick_int6 = srb_pick(hit_int6, word_int6);

  ////////////////////////////////////////////////////////////////////////////
  // first calibration result at 0x1b
  // 23-bit unsigned value in 22:0
  logic ld_cal1;
  logic hit_cal1;
  logic rd_cal1;
  logic wr_cal1;
  logic [23:0] word_cal1;
  logic [23:0] pick_cal1;

  assign ld_cal1 = srb_ld(load_in, SRB_SLOT_CAL_FIRST);
  assign hit_cal1 = srb_hit(req_in.addr, SRB_ADDR_CAL_FIRST);
  assign rd_cal1 = req_in.rd & hit_cal1;
  assign wr_cal1 = req_in.wr & hit_cal1;
  assign word_cal1 = srb_word(val_reg[SRB_SLOT_CAL_FIRST]);
  assign pick_cal1 = srb_pick(hit_cal1, word_cal1);

  ////////////////////////////////////////////////////////////////////////////
  // read select and strobe merge
  logic any_rd;
  logic any_wr;
  logic [23:0] sel_word;

  assign ld_vec = {ld_cal1, ld_int6, ld_cc5, ld_int5, ld_cc4, ld_int4, ld_cc3, ld_int3};
  assign any_rd = rd_int3 | rd_cc3 | rd_int4 | rd_cc4 |
                  rd_int5 | rd_cc5 | rd_int6 | rd_cal1;
  assign any_wr = wr_int3 | wr_cc3 | wr_int4 | wr_cc4 |
                  wr_int5 | wr_cc5 | wr_int6 | wr_cal1;
  assign sel_word = pick_int3 | pick_cc3 | pick_int4 | pick_cc4 |
                    pick_int5 | pick_cc5 | pick_int6 | pick_cal1;

  ////////////////////////////////////////////////////////////////////////////
  // read answer is registered; unmapped addresses read zero with rd_hit low
  logic [23:0] rd_data_reg;
  logic [23:0] rd_data_next;
  logic rd_hit_reg;
  logic rd_hit_next;
  logic wr_ignored_reg;
  logic wr_ignored_next;

  // rd_data holds between reads so a slow host can still pick it up
  assign rd_data_next = req_in.rd ? sel_word : rd_data_reg;
  assign rd_hit_next = any_rd;
  // a write is answered only as a flag; storage has no write path at all
  assign wr_ignored_next = any_wr;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rd_data_reg <= SRB_WORD_ZERO;
    end else begin
      rd_data_reg <= rd_data_next;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rd_hit_reg <= 1'b0;
    end else begin
      rd_hit_reg <= rd_hit_next;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wr_ignored_reg <= 1'b0;
    end else begin
      wr_ignored_reg <= wr_ignored_next;
    end
  end

  assign rd_data = rd_data_reg;
  assign rd_hit = rd_hit_reg;
  assign wr_ignored = wr_ignored_reg;

endmodule

// >>> srb_result_bank_monitor.sv
/* port checker for srb_result_bank
   assumes one clk_sys domain and async rst */
`timescale 1ns/1ps
module srb_result_bank_monitor
  import srb_pkg::*;
#(parameter int EXT_EN = 1) (
  // bank ports
  input wire logic clk_sys,
  input wire logic rst,
  input wire srb_load_s load_in,
  input wire logic averaging_en,
  input wire srb_req_s req_in,
  input wire logic [23:0] rd_data,
  input wire logic rd_hit,
  input wire logic wr_ignored
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  wire logic mapped = req_in.addr >= 6'h14 && req_in.addr <= 6'h1b;
  a_read_hit: assert property (req_in.rd && mapped |=> rd_hit)
    else $error("hit");
  a_miss_zero: assert property (req_in.rd && !mapped |=> !rd_hit && rd_data == 24'h00_0000)
    else $error("miss");
  a_idle_quiet: assert property (!req_in.rd |=> !rd_hit) else $error("idle");
  a_write_flag: assert property (req_in.wr && mapped |=> wr_ignored) else $error("wr");
  a_write_idle: assert property (!req_in.wr |=> !wr_ignored) else $error("wr idle");
  a_word_parity: assert property (rd_hit |-> rd_data[23] == ^rd_data[22:0])
    else $error("par");
  a_data_hold: assert property (!req_in.rd |=> $stable(rd_data)) else $error("hold");
  a_write_nohit: assert property (req_in.wr && !req_in.rd |=> !rd_hit)
    else $error("wr hit");
  c_read: cover property (rd_hit);
  c_write: cover property (wr_ignored);
  c_miss: cover property (req_in.rd && !mapped);
endmodule
bind srb_result_bank srb_result_bank_monitor #(.EXT_EN(EXT_EN)) u_mon (.clk_sys(clk_sys),
  .rst(rst), .load_in(load_in), .averaging_en(averaging_en), .req_in(req_in),
  .rd_data(rd_data), .rd_hit(rd_hit), .wr_ignored(wr_ignored));

// >>> srb_host_model.sv
/* host model on the register port
   assumes callers run just after a clock edge */
`timescale 1ns/1ps
module srb_host_model
  import srb_pkg::*;
(
  // clock and register port
  input wire logic clk_sys,
  output srb_req_s req_in
);
  initial req_in = '0;
  // idle address is inverted so a stale index never looks held
  task automatic access(logic r, logic w, logic [5:0] a);
    @(posedge clk_sys);
    #1;
    req_in = '{rd: r, wr: w, addr: a};
    @(posedge clk_sys);
    #1;
    req_in = '{rd: 1'b0, wr: 1'b0, addr: ~a};
  endtask
endmodule

// >>> stop_result_register_bank_tb.sv
/* testbench for srb_result_bank
   assumes srb_host_model drives the register port */
`timescale 1ns/1ps
module stop_result_register_bank_tb;
  import srb_pkg::*;
  logic clk_sys = 0;
  logic rst = 1;
  logic averaging_en = 0;
  srb_load_s load_in = '0;
  srb_req_s req_in;
  logic [23:0] rd_data;
  logic rd_hit;
  logic wr_ignored;
  int error_cnt = 0;
  int comparisons = 0;
  logic [22:0] v;
  logic [23:0] w [8];
  always #12.5 clk_sys = ~clk_sys;
  srb_result_bank u_dut (.clk_sys(clk_sys), .rst(rst), .load_in(load_in),
    .averaging_en(averaging_en), .req_in(req_in), .rd_data(rd_data), .rd_hit(rd_hit),
    .wr_ignored(wr_ignored));
  srb_host_model u_host (.clk_sys(clk_sys), .req_in(req_in));
  task automatic close_out;
    if (error_cnt == 0 && comparisons > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic acc(logic r, logic [5:0] a, logic [23:0] e, logic h);
    u_host.access(r, !r, a);
    comparisons++;
    if (rd_data !== e || (r ? rd_hit : wr_ignored) !== h) begin
      error_cnt++;
      $display("[ERR] %0t addr %h got %h", $time, a, rd_data);
    end
  endtask
  initial begin
    repeat (10) @(posedge clk_sys);
    #1;
    rst = 0;
    for (int i = 0; i < 8; i++) acc(1, 6'h14 + 6'(i), 24'h00_0000, 1);
    acc(1, 6'h1c, 24'h00_0000, 0);
    for (int i = 0; i < 8; i++) begin
      v = 23'h6a_5c3e ^ 23'(i);
      averaging_en = (i == 3);
      load_in = '{load: 1'b1, slot: srb_slot_e'(i), value: v};
      @(posedge clk_sys);
      #1;
      load_in.load = 1'b0;
      if (i % 2 == 1 && i < 7 && i != 3) v[22:16] = 7'h00;
      w[i] = {^v, v};
      acc(1, 6'h14 + 6'(i), w[i], 1);
    end
    for (int i = 0; i < 8; i++) acc(0, 6'h14 + 6'(i), w[7], 1);
    for (int i = 0; i < 8; i++) acc(1, 6'h14 + 6'(i), w[i], 1);
    // a reset in mid-run must clear every loaded word again
    rst = 1;
    @(posedge clk_sys);
    #1;
    rst = 0;
    for (int i = 0; i < 8; i++) acc(1, 6'h14 + 6'(i), 24'h00_0000, 1);
    close_out();
  end
  initial begin
    #20us;
    error_cnt++;
    close_out();
  end
endmodule
